// >>> design/qawd_consts.svh
/*
  constants for the multi-answer reply evaluator: encodings, reload values, counts.
  assumes inclusion by bare name from the package and the design modules.
*/
`ifndef QAWD_CONSTS_SVH
`define QAWD_CONSTS_SVH

// ==========================================================
// scheme select and counters
`define QAWD_SCHEME_MULTI 1'h0
`define QAWD_TALLY_W 2
`define QAWD_TALLY_MULTI 2'h3
`define QAWD_TALLY_SINGLE 2'h1
`define QAWD_TALLY_LAST 2'h0
`define QAWD_W1_FULL 2'h3
`define QAWD_TALLY_STEP 2'h1
`define QAWD_W1_ZERO 2'h0

// ==========================================================
// outcome flag positions in the packed flag vector
`define QAWD_FLAG_N 4
`define QAWD_F_WRONG 0
`define QAWD_F_EARLY 1
`define QAWD_F_ORDER 2
`define QAWD_F_TOUT 3
`define QAWD_FLAGS_CLEAR 4'h0

`endif

// >>> design/qawd_pkg.sv
/*
  types shared by the reply evaluator and its outcome register.
  assumes the constants header is on the include path.
*/
`include "qawd_consts.svh"

package qawd_pkg;
  // ==========================================================
  // response window phase within one guard cycle
  typedef enum logic {
    QAWD_WIN1,
    QAWD_WIN2
  } qawd_phase_t;

  typedef logic [`QAWD_TALLY_W-1:0] qawd_tally_t;
  typedef logic [`QAWD_FLAG_N-1:0] qawd_flags_t;
endpackage : qawd_pkg

// >>> design/qawd_outcome_reg.sv
/*
  guard outcome register: the four status flags of the last finished cycle.
  assumes set, clear and init pulses are synchronous one-cycle strobes.
*/
`include "qawd_consts.svh"

module qawd_outcome_reg (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic load_i,
  input wire qawd_pkg::qawd_flags_t load_val_i,
  input wire logic clear_i,
  output qawd_pkg::qawd_flags_t flags_o
);
  import qawd_pkg::*;

  qawd_flags_t flags_q;
  qawd_flags_t flags_d;

  // a cycle end landing with a read-clear wins, so the new outcome is never lost
  assign flags_d = load_i ? load_val_i : (clear_i ? `QAWD_FLAGS_CLEAR : flags_q);

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flags_q <= `QAWD_FLAGS_CLEAR;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flags_o = flags_q;
endmodule : qawd_outcome_reg

// >>> design/qawd_eval.sv
/*
  multi-answer reply evaluator of a question-and-answer watchdog.
  assumes the window timer, the question engine and the failure counter sit
  outside; window ends, replies, init and status reads arrive as one-cycle pulses.
*/
// What this block does
// [R1] multi-answer evaluation with two windows runs while scheme select is zero
// [R2] three good replies in window one, one in window two: end, decrement, flags clear
// [R3] only a correct sequence asks a new question; anything else increments, repeats
// [R4] the fourth reply of a cycle ends the cycle at once
// [R5] under four replies at window two end: timeout, increment, next cycle
// [R6] under three replies in window one then replies in window two: order fault
// [R7] one good reply in window one and none after: order fault and timeout
// [R8] any wrong reply in the cycle sets the wrong reply flag
// [R9] four replies inside window one: end at fourth, premature flag, increment
// [R10] a two-bit reply tally decides when four replies are reached
// [R11] status flags change only when a cycle ends; the code also clears them on a status read or init
// [R12] a status read returns the previous cycle flags and clears them
// [R13] any init loads the tally with three in multi-answer mode
// [R14] the controller gives three good replies then one good reply each cycle; the bench model sends per-burst counts of 0 to 4 replies, some wrong
`include "qawd_consts.svh"

module qawd_eval (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic reply_scheme_select_i,
  input wire logic init_i,
  input wire logic win1_end_i,
  input wire logic win2_end_i,
  input wire logic reply_valid_i,
  input wire logic reply_ok_i,
  input wire logic status_read_i,
  output logic cycle_end_o,
  output logic new_question_o,
  output logic fail_inc_o,
  output logic fail_dec_o,
  output qawd_pkg::qawd_tally_t reply_tally_o,
  output logic wrong_reply_flag_o,
  output logic premature_reply_flag_o,
  output logic order_fault_flag_o,
  output logic timeout_flag_o
);
  import qawd_pkg::*;

  // ==========================================================
  // cycle state
  qawd_phase_t phase_q;
  qawd_phase_t phase_d;
  qawd_tally_t tally_q;
  qawd_tally_t tally_d;
  qawd_tally_t w1_cnt_q;
  qawd_tally_t w1_cnt_d;
  logic any_wrong_q;
  logic any_wrong_d;
  logic end_q;
  logic newq_q;
  logic inc_q;
  logic dec_q;
  qawd_flags_t flags;

  // ==========================================================
  // decode
  // [R1] multi-answer only
  wire active = (reply_scheme_select_i == `QAWD_SCHEME_MULTI);
  wire in_w1 = (phase_q == QAWD_WIN1);
  wire ans = active && reply_valid_i && !init_i;
  // [R10] tally reaching zero marks the fourth reply
  wire fourth = ans && (tally_q == `QAWD_TALLY_LAST);
  // [R4] fourth reply closes the cycle now
  wire tout_end = active && !init_i && !in_w1 && win2_end_i && !fourth;
  wire end_d = fourth || tout_end;
  // [R8] sticky wrong reply within the cycle
  wire wrong_all = any_wrong_q || (ans && !reply_ok_i);
  wire w1_short = (w1_cnt_q != `QAWD_W1_FULL);
  // [R9] all four inside window one
  wire early = fourth && in_w1;
  // [R6] [R7] short window one followed by window two activity or silence
  wire order = !in_w1 && end_d && w1_short;
  // [R2] the only correct outcome
  wire good = fourth && !in_w1 && !w1_short && !wrong_all;
  // [R13] reload value depends on scheme
  wire [`QAWD_TALLY_W-1:0] reload = active ? `QAWD_TALLY_MULTI : `QAWD_TALLY_SINGLE;

  qawd_flags_t outcome;
  assign outcome[`QAWD_F_WRONG] = wrong_all;
  assign outcome[`QAWD_F_EARLY] = early;
  assign outcome[`QAWD_F_ORDER] = order;
  // [R5] timeout on window two end
  assign outcome[`QAWD_F_TOUT] = tout_end;

  // ==========================================================
  // next state
  wire restart = init_i || end_d;
  assign phase_d = restart ? QAWD_WIN1 : ((active && win1_end_i && in_w1) ? QAWD_WIN2 : phase_q);
  assign tally_d = restart ? reload : (ans ? tally_q - `QAWD_TALLY_STEP : tally_q);
  assign w1_cnt_d = restart ? `QAWD_W1_ZERO
                  : ((ans && in_w1) ? w1_cnt_q + `QAWD_TALLY_STEP : w1_cnt_q);
  assign any_wrong_d = restart ? 1'b0 : wrong_all;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      phase_q <= QAWD_WIN1;
      tally_q <= `QAWD_TALLY_MULTI;
      w1_cnt_q <= `QAWD_W1_ZERO;
      any_wrong_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      tally_q <= tally_d;
      w1_cnt_q <= w1_cnt_d;
      any_wrong_q <= any_wrong_d;
    end
  end

  // [R3] decrement and fresh question only on a correct sequence
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      end_q <= 1'b0;
      newq_q <= 1'b0;
      inc_q <= 1'b0;
      dec_q <= 1'b0;
    end else begin
      end_q <= end_d;
      newq_q <= good;
      inc_q <= end_d && !good;
      dec_q <= good;
    end
  end

  // ==========================================================
  // outcome register
  // [R11] [R12] load at cycle end, cleared by read or init
  qawd_outcome_reg u_outcome (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .load_i(end_d),
    .load_val_i(outcome),
    .clear_i(status_read_i || init_i),
    .flags_o(flags)
  );

  assign cycle_end_o = end_q;
  assign new_question_o = newq_q;
  assign fail_inc_o = inc_q;
  assign fail_dec_o = dec_q;
  assign reply_tally_o = tally_q;
  assign wrong_reply_flag_o = flags[`QAWD_F_WRONG];
  assign premature_reply_flag_o = flags[`QAWD_F_EARLY];
  assign order_fault_flag_o = flags[`QAWD_F_ORDER];
  assign timeout_flag_o = flags[`QAWD_F_TOUT];

  // ==========================================================
  // checks
  AST_SCHEME_IDLE: assert property ( // [R1]
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (reply_scheme_select_i != `QAWD_SCHEME_MULTI)
    |=> (!cycle_end_o && !fail_inc_o && !fail_dec_o))
    else $error("evaluation ran outside multi-answer mode");

  AST_GOOD_SEQ: assert property ( // [R2]
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (ans && !in_w1 && tally_q == `QAWD_TALLY_LAST &&
     w1_cnt_q == `QAWD_W1_FULL && !any_wrong_q && reply_ok_i)
    |=> (fail_dec_o && new_question_o && !fail_inc_o && flags == `QAWD_FLAGS_CLEAR))
    else $error("correct sequence not rewarded");

  AST_REPEAT_Q: assert property ( // [R3]
    @(posedge clk_sys_i) disable iff (!rstn_i)
    cycle_end_o |-> (new_question_o != fail_inc_o))
    else $error("question choice does not match outcome");

  AST_END_FOURTH: assert property ( // [R4]
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (active && reply_valid_i && !init_i && tally_q == `QAWD_TALLY_LAST) |=> cycle_end_o)
    else $error("cycle not ended at fourth reply");

  AST_TIMEOUT: assert property ( // [R5]
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (active && !init_i && !in_w1 && win2_end_i && !reply_valid_i)
    |=> (timeout_flag_o && fail_inc_o && cycle_end_o))
    else $error("window two expiry missed");

  AST_ORDER: assert property ( // [R6]
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (ans && !in_w1 && tally_q == `QAWD_TALLY_LAST && w1_cnt_q < `QAWD_W1_FULL)
    |=> (order_fault_flag_o && fail_inc_o && !timeout_flag_o))
    else $error("order fault missing");

  AST_LONE_REPLY: assert property ( // [R7]
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (active && !init_i && !in_w1 && win2_end_i && !reply_valid_i && !any_wrong_q &&
     w1_cnt_q == `QAWD_TALLY_STEP && tally_q == (`QAWD_TALLY_MULTI - `QAWD_TALLY_STEP))
    |=> (order_fault_flag_o && timeout_flag_o && !wrong_reply_flag_o))
    else $error("lone reply cycle not flagged as order fault and timeout");

  AST_WRONG: assert property ( // [R8]
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (ans && !reply_ok_i && tally_q == `QAWD_TALLY_LAST) |=> wrong_reply_flag_o)
    else $error("wrong reply not flagged");

  AST_EARLY: assert property ( // [R9]
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (ans && in_w1 && tally_q == `QAWD_TALLY_LAST)
    |=> (premature_reply_flag_o && fail_inc_o && !new_question_o))
    else $error("premature replies not flagged");

  AST_TALLY_STEP: assert property ( // [R10]
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (ans && tally_q != `QAWD_TALLY_LAST && !end_d)
    |=> (reply_tally_o == $past(tally_q) - `QAWD_TALLY_STEP))
    else $error("reply tally did not step");

  AST_FLAGS_HOLD: assert property ( // [R11]
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (!end_d && !status_read_i && !init_i) |=> $stable(flags))
    else $error("flags moved outside cycle end");

  AST_READ_CLR: assert property ( // [R12]
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (status_read_i && !end_d) |=> (flags == `QAWD_FLAGS_CLEAR))
    else $error("status read did not clear");

  AST_INIT_TALLY: assert property ( // [R13]
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (init_i && active) |=> (reply_tally_o == `QAWD_TALLY_MULTI && !cycle_end_o))
    else $error("init did not load tally");
endmodule : qawd_eval

// >>> tb/qawd_mcu_model.sv
/*
  answering controller model: a burst of replies per go pulse.
  assumes the bench waits for busy low before its next go.
*/
module qawd_mcu_model (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic go_i,
  input wire logic slow_i,
  input wire logic [2:0] cnt_i,
  input wire logic [3:0] bad_i,
  output logic reply_valid_o,
  output logic reply_ok_o,
  output logic busy_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] left_q;
  logic [3:0] bad_q;
  logic wait_q;
  assign busy_o = (left_q != 3'h0) || reply_valid_o;
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      left_q <= 3'h0;
      bad_q <= 4'h0;
      wait_q <= 1'h0;
      reply_valid_o <= 1'h0;
      reply_ok_o <= 1'h0;
    end else if (go_i) begin
      left_q <= cnt_i;
      bad_q <= bad_i;
      reply_valid_o <= 1'h0;
    end else if (left_q != 3'h0 && !wait_q) begin
      reply_valid_o <= 1'h1;
      reply_ok_o <= ~bad_q[0];
      bad_q <= bad_q >> 1;
      left_q <= left_q - 3'h1;
      wait_q <= slow_i;
    end else begin
      reply_valid_o <= 1'h0;
      // qualifier is meaningless off valid: keep it moving
      reply_ok_o <= ~reply_ok_o;
      wait_q <= 1'h0;
    end
  end
endmodule : qawd_mcu_model

// >>> tb/qawd_eval_tb.sv
/*
  bench of the reply evaluator: partner bursts, window pulses, flag checks.
  assumes the design files and the partner model compile first.
*/
`include "qawd_consts.svh"

module qawd_eval_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import qawd_pkg::*;
  logic clk_sys_i = 1'h0;
  logic rstn_i = 1'h0;
  logic sel = 1'h0, init = 1'h0, w1 = 1'h0, w2 = 1'h0, rd = 1'h0;
  logic go = 1'h0, slow = 1'h0;
  logic [2:0] cnt = 3'h0;
  logic [3:0] bad = 4'h0;
  logic rv, rok, busy, ce, nq, inc, dec, fw, fp, fo, ft;
  qawd_tally_t tally;
  qawd_flags_t prev = '0, e;
  logic [31:0] lfsr = 32'h733f6a80;
  int error_cnt = 0, comparisons = 0, cyc = 0, ends = 0, e0;
  always #50 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    ends <= ends + ((ce === 1'h1) ? 1 : 0);
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end
  qawd_eval dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .reply_scheme_select_i(sel),
    .init_i(init), .win1_end_i(w1), .win2_end_i(w2), .reply_valid_i(rv),
    .reply_ok_i(rok), .status_read_i(rd), .cycle_end_o(ce), .new_question_o(nq),
    .fail_inc_o(inc), .fail_dec_o(dec), .reply_tally_o(tally),
    .wrong_reply_flag_o(fw), .premature_reply_flag_o(fp), .order_fault_flag_o(fo),
    .timeout_flag_o(ft));
  qawd_mcu_model mcu (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .go_i(go), .slow_i(slow),
    .cnt_i(cnt), .bad_i(bad), .reply_valid_o(rv), .reply_ok_o(rok), .busy_o(busy));
  // ========
  // helpers
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nx
  // order fault whenever window one held under three replies, timeout under four in all
  function automatic logic [3:0] exp_flags(input int n1, input logic [3:0] b1, input int n2,
                                           input logic [3:0] b2);
    logic wrong;
    wrong = (|(b1 & 4'((1 << n1) - 1))) || (|(b2 & 4'((1 << n2) - 1)));
    return {n1 + n2 < 4, n1 < 3, n1 == 4, wrong};
  endfunction : exp_flags
  task automatic chk(input string n, input logic [3:0] s, input logic [3:0] x);
    comparisons++;
    if (s !== x) begin
      error_cnt++;
      $display("unexpected %s exp %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic burst(input logic [2:0] c, input logic [3:0] b);
    @(posedge clk_sys_i) go <= 1'h1;
    cnt <= c;
    bad <= b;
    slow <= lfsr[7];
    @(posedge clk_sys_i) go <= 1'h0;
    repeat (12) begin
      @(negedge clk_sys_i);
      if (!busy) break;
    end
  endtask : burst
  task automatic run(input int n1, input logic [3:0] b1, input int n2, input logic [3:0] b2);
    logic good;
    e = exp_flags(n1, b1, n2, b2);
    good = (n1 == 3) && (n2 == 1) && !e[`QAWD_F_WRONG];
    e0 = ends;
    burst(3'(n1), b1);
    if (n1 < 4) begin
      chk("tally", 4'(tally), 4'(3 - n1));
      chk("hold", {ft, fo, fp, fw}, prev);
      @(posedge clk_sys_i) w1 <= 1'h1;
      @(posedge clk_sys_i) w1 <= 1'h0;
      burst(3'(n2), b2);
      if (n1 + n2 < 4) begin
        @(posedge clk_sys_i) w2 <= 1'h1;
        @(posedge clk_sys_i) w2 <= 1'h0;
        @(negedge clk_sys_i);
      end
    end
    // the end pulse may already stand when the last reply burst returns
    for (int k = 0; k < 4 && ce !== 1'h1; k++) begin
      @(negedge clk_sys_i);
    end
    chk("end", 4'(ce), 4'h1);
    chk("flags", {ft, fo, fp, fw}, e);
    chk("pulses", {1'h0, nq, inc, dec}, good ? 4'h5 : 4'h2);
    chk("reload", 4'(tally), 4'h3);
    @(negedge clk_sys_i);
    chk("ends", 4'(ends - e0), 4'h1);
    prev = e;
    if (lfsr[3]) begin
      @(posedge clk_sys_i) rd <= 1'h1;
      @(posedge clk_sys_i) rd <= 1'h0;
      @(negedge clk_sys_i);
      chk("clear", {ft, fo, fp, fw}, 4'h0);
      prev = '0;
    end
  endtask : run
  task automatic summarize();
    $display("error_cnt %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize
  // ========
  // sequence
  initial begin
    repeat (10) @(posedge clk_sys_i);
    rstn_i <= 1'h1;
    @(negedge clk_sys_i);
    chk("tally rst", 4'(tally), 4'h3);
    e0 = ends;
    @(posedge clk_sys_i) sel <= 1'h1;
    burst(3'h4, 4'h0);
    repeat (3) @(negedge clk_sys_i);
    chk("idle", 4'(ends - e0), 4'h0);
    @(posedge clk_sys_i) init <= 1'h1;
    @(posedge clk_sys_i) init <= 1'h0;
    @(negedge clk_sys_i);
    chk("tally single", 4'(tally), 4'(`QAWD_TALLY_SINGLE));
    @(posedge clk_sys_i) sel <= 1'h0;
    init <= 1'h1;
    @(posedge clk_sys_i) init <= 1'h0;
    burst(3'h2, 4'h0);
    @(posedge clk_sys_i) init <= 1'h1;
    @(posedge clk_sys_i) init <= 1'h0;
    @(negedge clk_sys_i);
    chk("init", 4'(tally), 4'h3);
    run(3, 0, 1, 0);
    run(3, 0, 1, 1);
    run(4, 0, 0, 0);
    run(4, 4'h2, 0, 0);
    run(1, 0, 0, 0);
    run(0, 0, 0, 0);
    run(0, 0, 4, 0);
    run(2, 0, 1, 4'h1);
    run(3, 4'h7, 0, 0);
    run(3, 0, 1, 0);
    repeat (40) begin
      lfsr = nx(lfsr);
      run(lfsr[2:0] % 5, lfsr[11:8], lfsr[6:4] % (5 - lfsr[2:0] % 5), lfsr[15:12]);
    end
    summarize();
  end
endmodule : qawd_eval_tb
